// ===== design/lsf_status_flags.sv
// status flag and part identification registers of the light sensor
`timescale 1ns/1ps
module lsf_status_flags
   import lsf_pkg::*;
#(
   parameter logic [1:0] PART_CODE_LOW = LSF_PART_CODE_LOW_DEF,
   parameter logic [11:0] PART_CODE_HIGH = LSF_PART_CODE_HIGH_DEF
)
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // register access from the serial target
   input wire logic [7:0] reg_addr,
   input wire logic reg_rd,
   input wire logic reg_wr,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata,
   // conversion engine results
   input wire logic conv_done,
   input wire logic conv_overflow,
   input wire logic [LSF_SCALE_W-1:0] result_scale,
   input wire logic [LSF_MANT_W-1:0] result_mantissa,
   // limit and configuration settings
   input wire logic [LSF_SCALE_W-1:0] upper_limit_scale,
   input wire logic [LSF_LIMIT_W-1:0] upper_limit_value,
   input wire logic [LSF_SCALE_W-1:0] lower_limit_scale,
   input wire logic [LSF_LIMIT_W-1:0] lower_limit_value,
   input wire logic [1:0] fault_count,
   input wire logic [1:0] op_mode,
   input wire logic event_dir_input,
   input wire logic [1:0] event_cfg,
   input wire logic event_pol_high,
   // event pin
   input wire logic event_pin_i,
   output logic event_pin_o,
   output logic event_pin_oe,
   // measurement start request
   output logic one_shot_trigger,
   // status view
   output logic overrange_indicator,
   output logic sample_done_indicator,
   output logic above_limit_indicator,
   output logic below_limit_indicator
);
   // ==========================================
   // state
   logic overrange_q;
   logic overrange_d;
   logic done_q;
   logic done_d;
   logic [15:0] rdata_q;
   logic [15:0] rdata_d;
   logic above_q;
   logic below_q;

   // ==========================================
   // address decode
   wire hit_status = (reg_addr == LSF_ADDR_STATUS);
   wire hit_part_id = (reg_addr == LSF_ADDR_PART_ID);
   wire status_read = reg_rd && hit_status;
   wire status_wr_nz = reg_wr && hit_status && (reg_wdata != 16'h0000);
   wire status_touch = status_read || status_wr_nz;

   // ==========================================
   // limit comparison
   wire [LSF_LEVEL_W-1:0] result_level = lsf_form_level(result_scale, result_mantissa);
   wire [LSF_LEVEL_W-1:0] upper_level = lsf_form_level(upper_limit_scale,
                                           {upper_limit_value, {LSF_LIMIT_PAD{1'b0}}});
   wire [LSF_LEVEL_W-1:0] lower_level = lsf_form_level(lower_limit_scale,
                                           {lower_limit_value, {LSF_LIMIT_PAD{1'b0}}});
   wire above_violate = result_level > upper_level;
   wire below_violate = result_level < lower_level;

   lsf_hit_counter u_above (
      .ref_clk(ref_clk),
      .rst(rst),
      .sample_valid(conv_done),
      .violate(above_violate),
      .hit_code(fault_count),
      .clear(status_read),
      .flag_q(above_q)
   );

   lsf_hit_counter u_below (
      .ref_clk(ref_clk),
      .rst(rst),
      .sample_valid(conv_done),
      .violate(below_violate),
      .hit_code(fault_count),
      .clear(status_read),
      .flag_q(below_q)
   );

   // ==========================================
   // sticky indicators, a new event beats a clear
   assign overrange_d = (conv_done && conv_overflow) || (overrange_q && !status_read);
   assign done_d = conv_done || (done_q && !status_touch);

   // ==========================================
   // read data
   wire [15:0] status_word = {LSF_STATUS_UPPER_ZERO, overrange_q, done_q, above_q, below_q};
   wire [15:0] part_id_word = {LSF_PART_ID_TOP_ZERO, PART_CODE_LOW, PART_CODE_HIGH};
   assign rdata_d = !reg_rd ? rdata_q :
                    hit_status ? status_word :
                    hit_part_id ? part_id_word : 16'h0000;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         overrange_q <= 1'b0;
         done_q <= 1'b0;
         rdata_q <= LSF_STATUS_RESET;
      end else begin
         overrange_q <= overrange_d;
         done_q <= done_d;
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata = rdata_q;
   assign overrange_indicator = overrange_q;
   assign sample_done_indicator = done_q;
   assign above_limit_indicator = above_q;
   assign below_limit_indicator = below_q;

   // ==========================================
   // event pin
   lsf_event_pin u_event (
      .ref_clk(ref_clk),
      .rst(rst),
      .event_pin_i(event_pin_i),
      .event_pin_o(event_pin_o),
      .event_pin_oe(event_pin_oe),
      .event_dir_input(event_dir_input),
      .event_cfg(event_cfg),
      .event_pol_high(event_pol_high),
      .op_mode(op_mode),
      .sample_done(conv_done),
      .ready_flag(done_q),
      .limit_alert(above_q || below_q),
      .status_read(status_read),
      .one_shot_trigger(one_shot_trigger)
   );

   // ==========================================
   // checks
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);

   sequence s_status_read;
      reg_rd && reg_addr == LSF_ADDR_STATUS;
   endsequence

   property p_upper_zero;
      s_status_read |=> reg_rdata[15:4] == 12'h000;
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("status upper bits not zero");

   property p_overrange_set;
      conv_done && conv_overflow |=> overrange_indicator;
   endproperty
   a_overrange_set: assert property (p_overrange_set) else $error("overrange not raised");

   property p_done_set;
      conv_done |=> sample_done_indicator;
   endproperty
   a_done_set: assert property (p_done_set) else $error("sample done not set");

   property p_done_clear_read;
      s_status_read and !conv_done |=> !sample_done_indicator;
   endproperty
   a_done_clear_read: assert property (p_done_clear_read) else $error("read did not clear done");

   property p_done_clear_write;
      reg_wr && hit_status && reg_wdata != 16'h0000 && !conv_done |=> !sample_done_indicator;
   endproperty
   a_done_clear_write: assert property (p_done_clear_write) else $error("write did not clear done");

   property p_done_keep_zero_write;
      sample_done_indicator && !reg_rd && reg_wr && reg_wdata == 16'h0000 |=> sample_done_indicator;
   endproperty
   a_done_keep_zero_write: assert property (p_done_keep_zero_write) else $error("zero write cleared done");

   property p_read_shows_done;
      s_status_read and sample_done_indicator |=> reg_rdata[LSF_BIT_SAMPLE_DONE];
   endproperty
   a_read_shows_done: assert property (p_read_shows_done) else $error("status read lost done");

   property p_part_id;
      reg_rd && reg_addr == LSF_ADDR_PART_ID |=> reg_rdata == {2'h0, PART_CODE_LOW, PART_CODE_HIGH};
   endproperty
   a_part_id: assert property (p_part_id) else $error("part id wrong");

   property p_above_cause;
      $rose(above_limit_indicator) |-> $past(conv_done) && $past(above_violate);
   endproperty
   a_above_cause: assert property (p_above_cause) else $error("above set without violation");

   property p_below_cause;
      $rose(below_limit_indicator) |-> $past(conv_done) && $past(below_violate);
   endproperty
   a_below_cause: assert property (p_below_cause) else $error("below set without violation");

   property p_each_sample_pin;
      !event_dir_input && event_cfg == LSF_EVT_EACH_SAMPLE && !event_pol_high && conv_done
         |=> event_pin_oe;
   endproperty
   a_each_sample_pin: assert property (p_each_sample_pin) else $error("pin not asserted on sample");

   sequence s_overflow_sample;
      conv_done && conv_overflow;
   endsequence

   sequence s_nonzero_status_write;
      reg_wr && reg_addr == LSF_ADDR_STATUS && reg_wdata != 16'h0000;
   endsequence

   property p_overrange_clear;
      s_status_read and !(conv_done && conv_overflow) |=> !overrange_indicator;
   endproperty
   a_overrange_clear: assert property (p_overrange_clear) else $error("read did not clear overrange");

   property p_overrange_hold_low;
      !overrange_indicator && !(conv_done && conv_overflow) |=> !overrange_indicator;
   endproperty
   a_overrange_hold_low: assert property (p_overrange_hold_low) else $error("overrange rose alone");

   property p_overrange_keep;
      overrange_indicator && !reg_rd |=> overrange_indicator;
   endproperty
   a_overrange_keep: assert property (p_overrange_keep) else $error("overrange lost without read");

   property p_overrange_after_sample;
      s_overflow_sample |=> reg_rd or overrange_indicator;
   endproperty
   a_overrange_after_sample: assert property (p_overrange_after_sample) else $error("overrange missed");

   property p_write_keeps_flags;
      s_nonzero_status_write and !reg_rd && !conv_done
         |=> $stable(overrange_indicator) && $stable(above_limit_indicator) && $stable(below_limit_indicator);
   endproperty
   a_write_keeps_flags: assert property (p_write_keeps_flags) else $error("write changed a flag");

   property p_above_clear_read;
      s_status_read and !conv_done |=> !above_limit_indicator;
   endproperty
   a_above_clear_read: assert property (p_above_clear_read) else $error("read did not clear above");

   property p_below_clear_read;
      s_status_read and !conv_done |=> !below_limit_indicator;
   endproperty
   a_below_clear_read: assert property (p_below_clear_read) else $error("read did not clear below");

   property p_done_hold_low;
      !sample_done_indicator && !conv_done |=> !sample_done_indicator;
   endproperty
   a_done_hold_low: assert property (p_done_hold_low) else $error("sample done rose alone");

   property p_unmapped_read;
      reg_rd && reg_addr != LSF_ADDR_STATUS && reg_addr != LSF_ADDR_PART_ID |=> reg_rdata == 16'h0000;
   endproperty
   a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

   property p_rdata_hold;
      !reg_rd |=> $stable(reg_rdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

   property p_read_shows_overrange;
      s_status_read and overrange_indicator |=> reg_rdata[LSF_BIT_OVERRANGE];
   endproperty
   a_read_shows_overrange: assert property (p_read_shows_overrange) else $error("read lost overrange");

   property p_read_shows_above;
      s_status_read and above_limit_indicator |=> reg_rdata[LSF_BIT_ABOVE];
   endproperty
   a_read_shows_above: assert property (p_read_shows_above) else $error("read lost above");

   property p_read_shows_below;
      s_status_read and below_limit_indicator |=> reg_rdata[LSF_BIT_BELOW];
   endproperty
   a_read_shows_below: assert property (p_read_shows_below) else $error("read lost below");

   property p_limit_alert_pin;
      !event_dir_input && event_cfg == LSF_EVT_LIMIT_ALERT && !event_pol_high
         |-> event_pin_oe == (above_limit_indicator || below_limit_indicator);
   endproperty
   a_limit_alert_pin: assert property (p_limit_alert_pin) else $error("pin not following limits");

   property p_trigger_pulse;
      one_shot_trigger |=> !one_shot_trigger;
   endproperty
   a_trigger_pulse: assert property (p_trigger_pulse) else $error("trigger longer than a cycle");

   property p_trigger_mode;
      one_shot_trigger |-> op_mode == LSF_MODE_ONE_SHOT || op_mode == LSF_MODE_FORCED_ONE_SHOT;
   endproperty
   a_trigger_mode: assert property (p_trigger_mode) else $error("trigger outside one-shot");
endmodule : lsf_status_flags

// ===== design/lsf_pkg.sv
// shared constants for the light sensor status flag block
package lsf_pkg;
   // ==========================================
   // register offsets
   localparam logic [7:0] LSF_ADDR_STATUS = 8'h0C;
   localparam logic [7:0] LSF_ADDR_PART_ID = 8'h11;
   // ==========================================
   // status field positions
   localparam int LSF_BIT_OVERRANGE = 3;
   localparam int LSF_BIT_SAMPLE_DONE = 2;
   localparam int LSF_BIT_ABOVE = 1;
   localparam int LSF_BIT_BELOW = 0;
   localparam logic [11:0] LSF_STATUS_UPPER_ZERO = 12'h000;
   localparam logic [15:0] LSF_STATUS_RESET = 16'h0000;
   // ==========================================
   // part identification fields
   localparam logic [1:0] LSF_PART_ID_TOP_ZERO = 2'h0;
   localparam logic [1:0] LSF_PART_CODE_LOW_DEF = 2'h0;
   // arbitrary neutral value
   localparam logic [11:0] LSF_PART_CODE_HIGH_DEF = 12'h5A3;
   // ==========================================
   // field widths
   localparam int LSF_SCALE_W = 4;
   localparam int LSF_LIMIT_W = 12;
   localparam int LSF_MANT_W = 20;
   localparam int LSF_LEVEL_W = 36;
   localparam int LSF_LIMIT_PAD = 8;
   // ==========================================
   // operating modes and event pin configurations
   typedef enum logic [1:0] {
      LSF_MODE_OFF = 2'b00,
      LSF_MODE_FORCED_ONE_SHOT = 2'b01,
      LSF_MODE_ONE_SHOT = 2'b10,
      LSF_MODE_CONTINUOUS = 2'b11
   } lsf_mode_t;
   typedef enum logic [1:0] {
      LSF_EVT_LIMIT_ALERT = 2'b00,
      LSF_EVT_EACH_SAMPLE = 2'b01,
      LSF_EVT_INVALID = 2'b10,
      LSF_EVT_FOURTH_SAMPLE = 2'b11
   } lsf_evt_cfg_t;
   localparam logic [1:0] LSF_FOURTH_LAST = 2'h3;
   // ==========================================
   // consecutive hit targets
   localparam logic [3:0] LSF_HITS_1 = 4'h1;
   localparam logic [3:0] LSF_HITS_2 = 4'h2;
   localparam logic [3:0] LSF_HITS_4 = 4'h4;
   localparam logic [3:0] LSF_HITS_8 = 4'h8;

   function automatic logic [3:0] lsf_hit_target(input logic [1:0] code);
      logic [3:0] t;
      t = LSF_HITS_1;
      case (code)
         2'h1: t = LSF_HITS_2;
         2'h2: t = LSF_HITS_4;
         2'h3: t = LSF_HITS_8;
         default: t = LSF_HITS_1;
      endcase
      return t;
   endfunction : lsf_hit_target

   function automatic logic [LSF_LEVEL_W-1:0] lsf_form_level(input logic [LSF_SCALE_W-1:0] scale,
                                                              input logic [LSF_MANT_W-1:0] mant);
      logic [LSF_LEVEL_W-1:0] wide;
      wide = {{(LSF_LEVEL_W-LSF_MANT_W){1'b0}}, mant};
      return wide << scale;
   endfunction : lsf_form_level
endpackage : lsf_pkg

// ===== design/lsf_hit_counter.sv
// consecutive limit violation counter with sticky indicator
`timescale 1ns/1ps
module lsf_hit_counter
   import lsf_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // measurement stream
   input wire logic sample_valid,
   input wire logic violate,
   input wire logic [1:0] hit_code,
   // indicator control
   input wire logic clear,
   output logic flag_q
);
   logic [3:0] cnt_q;
   logic [3:0] cnt_d;
   logic flag_d;
   wire [3:0] target = lsf_hit_target(hit_code);
   wire [3:0] cnt_inc = cnt_q + 4'h1;
   wire hit = sample_valid && violate && (cnt_inc >= target);
   // ==========================================
   // counter and indicator
   assign cnt_d = !sample_valid ? cnt_q :
                  !violate ? 4'h0 :
                  (cnt_inc > target) ? cnt_q : cnt_inc;
   assign flag_d = hit || (flag_q && !clear);

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cnt_q <= 4'h0;
         flag_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         flag_q <= flag_d;
      end
   end

   // ==========================================
   // checks
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   property p_in_limit_resets;
      sample_valid && !violate |=> cnt_q == 4'h0;
   endproperty
   a_in_limit_resets: assert property (p_in_limit_resets) else $error("counter not reset");
   property p_hit_sets;
      sample_valid && violate && (cnt_q + 4'h1 >= lsf_hit_target(hit_code)) |=> flag_q;
   endproperty
   a_hit_sets: assert property (p_hit_sets) else $error("indicator not set at count");
   property p_no_early_set;
      !flag_q && !(sample_valid && violate) |=> !flag_q;
   endproperty
   a_no_early_set: assert property (p_no_early_set) else $error("indicator set early");
endmodule : lsf_hit_counter

// ===== design/lsf_event_pin.sv
// event pin driver and one-shot trigger detector
`timescale 1ns/1ps
module lsf_event_pin
   import lsf_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // pin
   input wire logic event_pin_i,
   output logic event_pin_o,
   output logic event_pin_oe,
   // configuration
   input wire logic event_dir_input,
   input wire logic [1:0] event_cfg,
   input wire logic event_pol_high,
   input wire logic [1:0] op_mode,
   // block events
   input wire logic sample_done,
   input wire logic ready_flag,
   input wire logic limit_alert,
   input wire logic status_read,
   output logic one_shot_trigger
);
   logic pin_prev_q;
   logic [1:0] quad_cnt_q;
   logic quad_q;
   wire one_shot = (op_mode == LSF_MODE_ONE_SHOT) || (op_mode == LSF_MODE_FORCED_ONE_SHOT);
   wire pin_active = event_pol_high ? event_pin_i : !event_pin_i;
   wire prev_active = event_pol_high ? pin_prev_q : !pin_prev_q;
   wire quad_set = sample_done && (quad_cnt_q == LSF_FOURTH_LAST);
   wire assert_evt = (event_cfg == LSF_EVT_EACH_SAMPLE) ? ready_flag :
                     (event_cfg == LSF_EVT_FOURTH_SAMPLE) ? quad_q :
                     (event_cfg == LSF_EVT_LIMIT_ALERT) ? limit_alert : 1'b0;
   // ==========================================
   // pin drive: open drain, pulled up outside
   assign event_pin_o = 1'b0;
   assign event_pin_oe = !event_dir_input && (event_pol_high ? !assert_evt : assert_evt);
   assign one_shot_trigger = event_dir_input && one_shot && pin_active && !prev_active;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pin_prev_q <= 1'b1;
         quad_cnt_q <= 2'h0;
         quad_q <= 1'b0;
      end else begin
         pin_prev_q <= event_pin_i;
         quad_cnt_q <= sample_done ? quad_cnt_q + 2'h1 : quad_cnt_q;
         quad_q <= quad_set || (quad_q && !status_read);
      end
   end

   // ==========================================
   // checks
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   property p_trigger_cause;
      one_shot_trigger |-> event_dir_input && one_shot && $changed(event_pin_i);
   endproperty
   a_trigger_cause: assert property (p_trigger_cause) else $error("trigger without pin edge");
   property p_input_released;
      event_dir_input |-> !event_pin_oe;
   endproperty
   a_input_released: assert property (p_input_released) else $error("pin driven while input");
endmodule : lsf_event_pin

// ===== dv/lsf_host_model.sv
// host side model of the open-drain event line
`timescale 1ns/1ps
module lsf_host_model
   import lsf_pkg::*;
(
   // device side of the line
   dev_o,
   dev_oe,
   // host side request
   host_pull,
   // resolved line level
   line_level
);
   input wire logic dev_o;
   input wire logic dev_oe;
   input wire logic host_pull;
   output logic line_level;
   // ====================
   // open-drain line with pull-up
   assign line_level = ((dev_oe && !dev_o) || host_pull) ? 1'b0 : 1'b1;
endmodule : lsf_host_model

// ===== dv/test_lsf_status_flags.sv
// self-checking bench for the status flag register block
`timescale 1ns/1ps
module test_lsf_status_flags;
   import lsf_pkg::*;
   // ====================
   // constants
   localparam logic [1:0] ID_LOW = 2'h2; // arbitrary value
   localparam logic [11:0] ID_HIGH = 12'h3C6; // arbitrary value
   localparam logic [15:0] ID_WORD = {LSF_PART_ID_TOP_ZERO, ID_LOW, ID_HIGH};
   // ====================
   // signals
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic reg_rd = 1'b0;
   logic reg_wr = 1'b0;
   logic [15:0] reg_wdata = 16'h0000;
   logic [15:0] reg_rdata;
   logic conv_done = 1'b0;
   logic conv_overflow = 1'b0;
   logic [LSF_SCALE_W-1:0] result_scale = 4'h0;
   logic [LSF_MANT_W-1:0] result_mantissa = 20'h00000;
   logic [LSF_SCALE_W-1:0] upper_limit_scale = 4'h0;
   logic [LSF_LIMIT_W-1:0] upper_limit_value = 12'h100;
   logic [LSF_SCALE_W-1:0] lower_limit_scale = 4'h0;
   logic [LSF_LIMIT_W-1:0] lower_limit_value = 12'h004;
   logic [1:0] fault_count = 2'h0;
   logic [1:0] op_mode = 2'h3;
   logic event_dir_input = 1'b0;
   logic [1:0] event_cfg = 2'h1;
   logic event_pol_high = 1'b0;
   logic host_pull = 1'b0;
   logic event_pin_o;
   logic event_pin_oe;
   logic pin_level;
   logic one_shot_trigger;
   logic ovr_ind;
   logic done_ind;
   logic above_ind;
   logic below_ind;
   logic [LSF_MANT_W-1:0] mant;
   int hits;
   int n_conv = 0;
   int err_total = 0;
   int n_checks = 0;
   // ====================
   // clock, design and host model
   always #10 ref_clk = ~ref_clk;
   lsf_status_flags #(.PART_CODE_LOW(ID_LOW), .PART_CODE_HIGH(ID_HIGH)) i_dut (
      .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .conv_done(conv_done), .conv_overflow(conv_overflow),
      .result_scale(result_scale), .result_mantissa(result_mantissa),
      .upper_limit_scale(upper_limit_scale), .upper_limit_value(upper_limit_value),
      .lower_limit_scale(lower_limit_scale), .lower_limit_value(lower_limit_value),
      .fault_count(fault_count), .op_mode(op_mode), .event_dir_input(event_dir_input),
      .event_cfg(event_cfg), .event_pol_high(event_pol_high), .event_pin_i(pin_level),
      .event_pin_o(event_pin_o), .event_pin_oe(event_pin_oe), .one_shot_trigger(one_shot_trigger),
      .overrange_indicator(ovr_ind), .sample_done_indicator(done_ind),
      .above_limit_indicator(above_ind), .below_limit_indicator(below_ind));
   lsf_host_model i_host (.dev_o(event_pin_o), .dev_oe(event_pin_oe), .host_pull(host_pull),
      .line_level(pin_level));
   // ====================
   // compare and access tasks
   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: word got %h expected %h", $time, got, exp);
      end
   endtask : chk_word
   task automatic chk_bit(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: bit got %b expected %b", $time, got, exp);
      end
   endtask : chk_bit
   task automatic reg_read(input logic [7:0] addr, input logic [15:0] exp);
      @(negedge ref_clk);
      reg_addr = addr;
      reg_rd = 1'b1;
      @(negedge ref_clk);
      reg_rd = 1'b0;
      chk_word(reg_rdata, exp);
   endtask : reg_read
   task automatic reg_write(input logic [7:0] addr, input logic [15:0] data);
      @(negedge ref_clk);
      reg_addr = addr;
      reg_wdata = data;
      reg_wr = 1'b1;
      @(negedge ref_clk);
      reg_wr = 1'b0;
   endtask : reg_write
   task automatic conv(input logic ovf, input logic [LSF_MANT_W-1:0] m);
      @(negedge ref_clk);
      conv_done = 1'b1;
      conv_overflow = ovf;
      result_mantissa = m;
      @(negedge ref_clk);
      conv_done = 1'b0;
      conv_overflow = 1'b0;
      n_conv++;
   endtask : conv
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_of_test
   // ====================
   // hang guard
   initial begin
      repeat (5000) @(posedge ref_clk);
      err_total++;
      $display("mismatch at %0t: run did not finish", $time);
      end_of_test();
   end
   // ====================
   // main sequence
   initial begin
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      rst = 1'b0;
      // reset values, identification, unmapped place
      reg_read(LSF_ADDR_STATUS, 16'h0000);
      reg_read(LSF_ADDR_PART_ID, ID_WORD);
      reg_write(LSF_ADDR_PART_ID, 16'h0ABC);
      reg_read(LSF_ADDR_PART_ID, ID_WORD);
      reg_read(8'h0D, 16'h0000);
      // overflow, done flag, each-sample event, read clear
      conv(1'b1, 20'h08000);
      chk_bit(ovr_ind, 1'b1);
      chk_bit(done_ind, 1'b1);
      chk_bit(pin_level, 1'b0);
      reg_read(LSF_ADDR_STATUS, 16'h000C);
      chk_bit(done_ind, 1'b0);
      chk_bit(pin_level, 1'b1);
      reg_read(LSF_ADDR_STATUS, 16'h0000);
      // zero write keeps done, non-zero write clears it
      conv(1'b0, 20'h08000);
      reg_write(LSF_ADDR_STATUS, 16'h0000);
      chk_bit(done_ind, 1'b1);
      reg_write(LSF_ADDR_STATUS, 16'h0004);
      chk_bit(done_ind, 1'b0);
      reg_read(LSF_ADDR_STATUS, 16'h0000);
      // limit counts for every hit code, both directions
      event_cfg = 2'h0;
      for (int code = 0; code < 4; code++) begin
         fault_count = code[1:0];
         hits = 1 << code;
         for (int dir = 0; dir < 2; dir++) begin
            mant = (dir == 1) ? 20'h00100 : 20'h20000;
            repeat (hits - 1) conv(1'b0, mant);
            conv(1'b0, 20'h08000);
            repeat (hits - 1) conv(1'b0, mant);
            chk_bit((dir == 1) ? below_ind : above_ind, 1'b0);
            conv(1'b0, mant);
            chk_bit((dir == 1) ? below_ind : above_ind, 1'b1);
            chk_bit(pin_level, 1'b0);
            reg_read(LSF_ADDR_STATUS, (dir == 1) ? 16'h0005 : 16'h0006);
            chk_bit(pin_level, 1'b1);
         end
      end
      // every fourth sample on the pin, cleared by a status read
      event_cfg = 2'h3;
      repeat ((3 - n_conv % 4 + 4) % 4) conv(1'b0, 20'h08000);
      chk_bit(pin_level, 1'b1);
      conv(1'b0, 20'h08000);
      chk_bit(pin_level, 1'b0);
      reg_read(LSF_ADDR_STATUS, 16'h0004);
      chk_bit(pin_level, 1'b1);
      event_pol_high = 1'b1;
      @(negedge ref_clk);
      chk_bit(pin_level, 1'b0);
      // event pin as input, trigger only in one-shot modes
      event_dir_input = 1'b1;
      event_pol_high = 1'b1;
      for (int m = 0; m < 4; m++) begin
         op_mode = m[1:0];
         @(negedge ref_clk);
         host_pull = 1'b1;
         @(negedge ref_clk);
         host_pull = 1'b0;
         #1;
         chk_bit(one_shot_trigger, (m == 1 || m == 2));
         @(negedge ref_clk);
         chk_bit(one_shot_trigger, 1'b0);
      end
      end_of_test();
   end
endmodule : test_lsf_status_flags
